//--- hw/occ_consts.svh
// Constants of the cache control block
//
// Functional notes
// - Both bits set: no fills, write-through, invalidates
// - Disabled mode: write hits stay inside cache
// - Fill disable only: write-through and invalidates continue
// - Loading invalid bit pair raises fault, code zero
// - Both bits clear: fills, write-through, invalidates on
// - Valid lines still hit while fills disabled
// - Read hit from cache, miss goes external
// - Cacheable read miss fills whole sixteen-byte line
// - Allocate on read miss only; write hits update
// - Pick first invalid way, scanning 0 to 3
// - Reset or flush clears every valid bit
// - Three history bits per set, updated each hit/replace
// - Pair bit one for ways 0/1
// - Pair bits track latest way within pair
// - Full set: pair bit, then pair bit picks victim
// - Reset or flush zeroes all history bits
// - Page attributes driven on pins each access
// - Page write-through ignored internally
// - Fill only if page attribute and cacheable input low
// - Cache-disable bit forces page cache-disable pin high
// - Paging bypass cycles use directory base attributes
// - Normal, table, directory cycles pick their attributes
// - Write-through on: every write goes external
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

// Register byte offsets
`define OCC_OFS_CTRL 12'h000
`define OCC_OFS_PDBR 12'h004
`define OCC_OFS_STAT 12'h008
`define OCC_OFS_CMD 12'h00C

// Machine control register fields
`define OCC_CTRL_CD_BIT 0
`define OCC_CTRL_NW_BIT 1
`define OCC_CTRL_CD_RST 1'b0
`define OCC_CTRL_NW_RST 1'b0

// Page directory base register attribute fields
`define OCC_PDBR_PWT_BIT 0
`define OCC_PDBR_PCD_BIT 1
`define OCC_PDBR_PWT_RST 1'b0
`define OCC_PDBR_PCD_RST 1'b0

// Status register fields
`define OCC_STAT_FAULT_BIT 0
`define OCC_STAT_CODE_LSB 8
`define OCC_STAT_CODE_MSB 15
`define OCC_STAT_BUSY_BIT 16
`define OCC_FAULT_CODE 8'h00

// Command register fields
`define OCC_CMD_FLUSH_BIT 0

// Pin synchroniser bit positions and idle levels
`define OCC_PIN_KEN 0
`define OCC_PIN_ACK 1
`define OCC_PIN_FLUSH 2
`define OCC_PIN_IDLE 3'b101

// Line address split
`define OCC_LINE_OFS_W 4

`endif

//--- hw/occ_pkg.sv
// Types shared by the cache control block
package occ_pkg;
    // Controller states, one-hot
    typedef enum logic [2:0]
    {
        OCC_ST_IDLE = 3'b001,
        OCC_ST_BUS = 3'b010,
        OCC_ST_DONE = 3'b100
    } occ_state_t;

    // Kind of bus cycle requested by the core
    typedef enum logic [1:0]
    {
        OCC_KIND_NORMAL = 2'b00,
        OCC_KIND_PTAB = 2'b01,
        OCC_KIND_PDIR = 2'b10,
        OCC_KIND_BYPASS = 2'b11
    } occ_kind_t;
endpackage

//--- hw/occ_ctrl.sv
// Cache control logic
`timescale 1ns/100ps
`include "occ_consts.svh"

module occ_ctrl
#(
    parameter int SETS = 128,
    parameter int TAG_W = 21
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [31:0] req_addr,
    input wire logic [1:0] req_kind,
    input wire logic pte_pwt,
    input wire logic pte_pcd,
    input wire logic pde_pwt,
    input wire logic pde_pcd,
    output logic req_ready,
    output logic resp_done,
    output logic resp_hit,
    output logic [1:0] resp_way,
    // Data array strobes
    output logic cache_wr_en,
    output logic [1:0] cache_wr_way,
    output logic [$clog2(SETS)-1:0] cache_wr_set,
    output logic line_fill,
    // Invalidation request from the core side
    input wire logic inval_valid,
    input wire logic [31:0] inval_addr,
    // External bus and pins
    output logic ext_req,
    output logic ext_write,
    output logic page_write_through,
    output logic page_cache_disable,
    input wire logic ext_ack,
    input wire logic cacheable_input_n,
    input wire logic flush_n,
    output logic gp_fault
);
    localparam int SET_W = $clog2(SETS);
    localparam int WAYS = 4;

    ////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed
    {
        occ_pkg::occ_state_t state; // Controller state
        logic cache_disable_bit; // Machine control register
        logic no_writethrough_bit; // Machine control register
        logic pdbr_pwt; // Directory base attributes
        logic pdbr_pcd;
        logic fault; // Sticky fault flag
        logic [2:0] sync1; // Pin synchroniser stages
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] pin_q; // Accepted pin levels
        logic [SET_W-1:0] set; // Held request
        logic [TAG_W-1:0] tag;
        logic wr;
        logic hit;
        logic [1:0] hway;
        logic page_pcd;
        logic [SETS-1:0][WAYS-1:0] valid; // Valid bits
        logic [SETS-1:0][2:0] lru; // {high pair, low pair, pair select}
        logic [SETS-1:0][WAYS-1:0][TAG_W-1:0] tags; // Tag store
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic req_ready;
        logic resp_done;
        logic resp_hit;
        logic [1:0] resp_way;
        logic cache_wr_en;
        logic [1:0] cache_wr_way;
        logic [SET_W-1:0] cache_wr_set;
        logic line_fill;
        logic ext_req;
        logic ext_write;
        logic pwt_pin;
        logic pcd_pin;
        logic gp_fault;
    } occ_regs_t;

    occ_regs_t st_r; // Registered state
    occ_regs_t st_nxt; // Next state

    ////////////////////////////////////////////////////////////////////////
    // Per-way tag compare
    logic [SET_W-1:0] req_set;
    logic [TAG_W-1:0] req_tag;
    logic [SET_W-1:0] inv_set;
    logic [TAG_W-1:0] inv_tag;
    logic [WAYS-1:0] req_match; // Hit vector of incoming request
    logic [WAYS-1:0] inv_match; // Hit vector of invalidation

    assign req_set = req_addr[`OCC_LINE_OFS_W +: SET_W];
    assign req_tag = req_addr[`OCC_LINE_OFS_W + SET_W +: TAG_W];
    assign inv_set = inval_addr[`OCC_LINE_OFS_W +: SET_W];
    assign inv_tag = inval_addr[`OCC_LINE_OFS_W + SET_W +: TAG_W];

    // One comparator pair per way
    genvar gw;
    generate
        for (gw = 0; gw < WAYS; gw++)
        begin : g_way
            assign req_match[gw] = st_r.valid[req_set][gw] && (st_r.tags[req_set][gw] == req_tag);
            assign inv_match[gw] = st_r.valid[inv_set][gw] && (st_r.tags[inv_set][gw] == inv_tag);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Encode a one-hot hit vector as a way number
    function automatic logic [1:0] way_enc(input logic [WAYS-1:0] m);
        logic [1:0] w;
        w = 2'h0;
        if (m[1])
            w = 2'h1;
        if (m[2])
            w = 2'h2;
        if (m[3])
            w = 2'h3;
        return w;
    endfunction

    // History after an access to way w
    function automatic logic [2:0] lru_touch(input logic [2:0] h, input logic [1:0] w);
        logic [2:0] o;
        o = h;
        o[0] = ~w[1];
        if (!w[1])
            o[1] = ~w[0];
        else
            o[2] = ~w[0];
        return o;
    endfunction

    // Victim way: first invalid, else tree decision
    function automatic logic [1:0] victim(input logic [WAYS-1:0] v, input logic [2:0] h);
        logic [1:0] w;
        if (!v[0])
            w = 2'h0;
        else if (!v[1])
            w = 2'h1;
        else if (!v[2])
            w = 2'h2;
        else if (!v[3])
            w = 2'h3;
        else if (h[0])
            w = h[2] ? 2'h3 : 2'h2;
        else
            w = h[1] ? 2'h1 : 2'h0;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    logic sel_pwt; // Attributes of the incoming request
    logic sel_pcd;
    logic ack_evt; // Accepted rising edge of ext_ack
    logic ken_ok; // Cacheable input accepted low
    logic flush_req; // Software flush from the command register
    logic apb_wr; // Write completing this edge
    logic [1:0] vway; // Chosen victim

    always_comb
    begin
        st_nxt = st_r;
        sel_pwt = 1'b0;
        sel_pcd = 1'b0;
        vway = 2'h0;
        flush_req = 1'b0;

        // Pin synchronisers, accept on agreement of stages two and three
        st_nxt.sync1 = {~flush_n, ext_ack, cacheable_input_n} ^ 3'b100;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.pin_q = (st_r.sync2 & st_r.sync3) | (st_r.pin_q & (st_r.sync2 ^ st_r.sync3));
        ack_evt = st_nxt.pin_q[`OCC_PIN_ACK] && !st_r.pin_q[`OCC_PIN_ACK];
        ken_ok = !st_nxt.pin_q[`OCC_PIN_KEN];

        // Pulses default low
        st_nxt.resp_done = 1'b0;
        st_nxt.resp_hit = 1'b0;
        st_nxt.cache_wr_en = 1'b0;
        st_nxt.line_fill = 1'b0;
        st_nxt.gp_fault = 1'b0;

        // APB: ready answered in the access cycle, effects at completion
        apb_wr = psel && penable && st_r.pready && pwrite;
        st_nxt.pready = psel && !penable;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable)
        begin
            st_nxt.prdata = 32'h0000_0000;
            case (paddr)
                `OCC_OFS_CTRL:
                begin
                    st_nxt.prdata[`OCC_CTRL_CD_BIT] = st_r.cache_disable_bit;
                    st_nxt.prdata[`OCC_CTRL_NW_BIT] = st_r.no_writethrough_bit;
                    // Invalid pair refused with an error answer
                    st_nxt.pslverr = pwrite && !pwdata[`OCC_CTRL_CD_BIT] && pwdata[`OCC_CTRL_NW_BIT];
                end
                `OCC_OFS_PDBR:
                begin
                    st_nxt.prdata[`OCC_PDBR_PWT_BIT] = st_r.pdbr_pwt;
                    st_nxt.prdata[`OCC_PDBR_PCD_BIT] = st_r.pdbr_pcd;
                end
                `OCC_OFS_STAT:
                begin
                    st_nxt.prdata[`OCC_STAT_FAULT_BIT] = st_r.fault;
                    st_nxt.prdata[`OCC_STAT_CODE_MSB:`OCC_STAT_CODE_LSB] = `OCC_FAULT_CODE;
                    st_nxt.prdata[`OCC_STAT_BUSY_BIT] = !st_r.state[0];
                end
                `OCC_OFS_CMD:
                    st_nxt.prdata = 32'h0000_0000;
                // Unmapped address
                default:
                    st_nxt.pslverr = 1'b1;
            endcase
        end
        if (apb_wr)
        begin
            case (paddr)
                `OCC_OFS_CTRL:
                begin
                    // Invalid combination keeps old mode and faults
                    if (!pwdata[`OCC_CTRL_CD_BIT] && pwdata[`OCC_CTRL_NW_BIT])
                    begin
                        st_nxt.gp_fault = 1'b1;
                    end
                    else
                    begin
                        st_nxt.cache_disable_bit = pwdata[`OCC_CTRL_CD_BIT];
                        st_nxt.no_writethrough_bit = pwdata[`OCC_CTRL_NW_BIT];
                    end
                end
                `OCC_OFS_PDBR:
                begin
                    st_nxt.pdbr_pwt = pwdata[`OCC_PDBR_PWT_BIT];
                    st_nxt.pdbr_pcd = pwdata[`OCC_PDBR_PCD_BIT];
                end
                // Write one to clear fault
                `OCC_OFS_STAT:
                    if (pwdata[`OCC_STAT_FAULT_BIT])
                        st_nxt.fault = 1'b0;
                `OCC_OFS_CMD:
                    flush_req = pwdata[`OCC_CMD_FLUSH_BIT];
                default:
                    st_nxt.fault = st_nxt.fault;
            endcase
        end
        // Set wins over clear
        if (st_nxt.gp_fault)
            st_nxt.fault = 1'b1;

        // Attribute source by cycle kind
        case (occ_pkg::occ_kind_t'(req_kind))
            occ_pkg::OCC_KIND_NORMAL:
            begin
                sel_pwt = pte_pwt;
                sel_pcd = pte_pcd;
            end
            occ_pkg::OCC_KIND_PTAB:
            begin
                sel_pwt = pde_pwt;
                sel_pcd = pde_pcd;
            end
            default:
            begin
                sel_pwt = st_r.pdbr_pwt;
                sel_pcd = st_r.pdbr_pcd;
            end
        endcase

        // Request sequencing
        case (st_r.state)
            occ_pkg::OCC_ST_IDLE:
            begin
                if (req_valid && st_r.req_ready)
                begin
                    st_nxt.req_ready = 1'b0;
                    st_nxt.set = req_set;
                    st_nxt.tag = req_tag;
                    st_nxt.wr = req_write;
                    st_nxt.hit = |req_match;
                    st_nxt.hway = way_enc(req_match);
                    st_nxt.page_pcd = sel_pcd;
                    // Write-through attribute goes to the pin only
                    st_nxt.pwt_pin = sel_pwt;
                    st_nxt.pcd_pin = st_r.cache_disable_bit | sel_pcd;
                    if (|req_match)
                    begin
                        // Hits refresh history; valid lines hit in every mode
                        st_nxt.lru[req_set] = lru_touch(st_r.lru[req_set], way_enc(req_match));
                    end
                    if (!req_write && (|req_match))
                    begin
                        // Read hit served from the cache
                        st_nxt.state = occ_pkg::OCC_ST_DONE;
                    end
                    else if (req_write && (|req_match) && st_r.no_writethrough_bit)
                    begin
                        // Hit updates cache only, no bus cycle
                        st_nxt.cache_wr_en = 1'b1;
                        st_nxt.cache_wr_way = way_enc(req_match);
                        st_nxt.cache_wr_set = req_set;
                        st_nxt.state = occ_pkg::OCC_ST_DONE;
                    end
                    else
                    begin
                        // Read miss, or write going out to memory
                        st_nxt.ext_req = 1'b1;
                        st_nxt.ext_write = req_write;
                        if (req_write && (|req_match))
                        begin
                            st_nxt.cache_wr_en = 1'b1;
                            st_nxt.cache_wr_way = way_enc(req_match);
                            st_nxt.cache_wr_set = req_set;
                        end
                        st_nxt.state = occ_pkg::OCC_ST_BUS;
                    end
                end
            end
            occ_pkg::OCC_ST_BUS:
            begin
                if (ack_evt)
                begin
                    st_nxt.ext_req = 1'b0;
                    st_nxt.ext_write = 1'b0;
                    // Allocate on cacheable read miss with fills enabled
                    if (!st_r.wr && !st_r.cache_disable_bit && !st_r.page_pcd && ken_ok)
                    begin
                        vway = victim(st_r.valid[st_r.set], st_r.lru[st_r.set]);
                        st_nxt.valid[st_r.set][vway] = 1'b1;
                        st_nxt.tags[st_r.set][vway] = st_r.tag;
                        st_nxt.lru[st_r.set] = lru_touch(st_r.lru[st_r.set], vway);
                        st_nxt.line_fill = 1'b1;
                        st_nxt.cache_wr_en = 1'b1;
                        st_nxt.cache_wr_way = vway;
                        st_nxt.cache_wr_set = st_r.set;
                        st_nxt.hway = vway;
                    end
                    st_nxt.state = occ_pkg::OCC_ST_DONE;
                end
            end
            occ_pkg::OCC_ST_DONE:
            begin
                // One-cycle completion report
                st_nxt.resp_done = 1'b1;
                st_nxt.resp_hit = st_r.hit;
                st_nxt.resp_way = st_r.hway;
                st_nxt.req_ready = 1'b1;
                st_nxt.state = occ_pkg::OCC_ST_IDLE;
            end
            default:
                st_nxt.state = occ_pkg::OCC_ST_IDLE;
        endcase

        // Invalidation, blocked while write-through is off
        if (inval_valid && !st_r.no_writethrough_bit)
        begin
            for (int i = 0; i < WAYS; i++)
                if (inv_match[i])
                    st_nxt.valid[inv_set][i] = 1'b0;
        end

        // Flush from pin or command clears valid and history
        if (flush_req || !st_r.pin_q[`OCC_PIN_FLUSH])
        begin
            st_nxt.valid = '0;
            st_nxt.lru = '0;
        end

        // Synchronous reset to defined values
        if (!rst_n)
        begin
            st_nxt = '0;
            st_nxt.state = occ_pkg::OCC_ST_IDLE;
            st_nxt.cache_disable_bit = `OCC_CTRL_CD_RST;
            st_nxt.no_writethrough_bit = `OCC_CTRL_NW_RST;
            st_nxt.pdbr_pwt = `OCC_PDBR_PWT_RST;
            st_nxt.pdbr_pcd = `OCC_PDBR_PCD_RST;
            st_nxt.sync1 = `OCC_PIN_IDLE;
            st_nxt.sync2 = `OCC_PIN_IDLE;
            st_nxt.sync3 = `OCC_PIN_IDLE;
            st_nxt.pin_q = `OCC_PIN_IDLE;
            st_nxt.req_ready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign req_ready = st_r.req_ready;
    assign resp_done = st_r.resp_done;
    assign resp_hit = st_r.resp_hit;
    assign resp_way = st_r.resp_way;
    assign cache_wr_en = st_r.cache_wr_en;
    assign cache_wr_way = st_r.cache_wr_way;
    assign cache_wr_set = st_r.cache_wr_set;
    assign line_fill = st_r.line_fill;
    assign ext_req = st_r.ext_req;
    assign ext_write = st_r.ext_write;
    assign page_write_through = st_r.pwt_pin;
    assign page_cache_disable = st_r.pcd_pin;
    assign gp_fault = st_r.gp_fault;
endmodule

//--- verification/occ_ctrl_asserts.sv
// Cache control checks
`timescale 1ns/100ps
module occ_ctrl_asserts
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic resp_done,
    input wire logic resp_hit,
    input wire logic [1:0] resp_way,
    input wire logic cache_wr_en,
    input wire logic [1:0] cache_wr_way,
    input wire logic line_fill,
    input wire logic ext_req,
    input wire logic ext_ack,
    input wire logic page_write_through,
    input wire logic page_cache_disable,
    input wire logic gp_fault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Refused mode write
    sequence s_bad_mode;
        psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'b10;
    endsequence
    // Bus end, then answer
    sequence s_bus_end;
        $fell(ext_req) ##1 resp_done;
    endsequence
    AST_BAD_MODE: assert property (s_bad_mode |-> pslverr ##[1:2] gp_fault)
        else $error("no fault");
    AST_FAULT_CAUSE: assert property (gp_fault |-> $past(pslverr && pwrite && paddr == 12'h000) || $past(pslverr && pwrite && paddr == 12'h000, 2))
        else $error("stray fault");
    AST_FILL_END: assert property (line_fill |-> !page_cache_disable ##0 s_bus_end)
        else $error("bad fill end");
    AST_FILL_WREN: assert property (line_fill |-> cache_wr_en ##1 (!resp_hit && resp_way == $past(cache_wr_way)))
        else $error("fill way not reported");
    AST_PIN_HOLD: assert property (!$stable({page_cache_disable, page_write_through}) |-> $past(req_valid && req_ready))
        else $error("pins moved");
    AST_DONE_CAUSE: assert property (resp_done |-> $past(req_valid && req_ready, 2) || $past(ext_req, 2))
        else $error("answer with wrong latency");
    AST_MISS_BUS: assert property (resp_done && !resp_hit |-> $past(ext_req, 2))
        else $error("miss without bus");
    AST_EXT_HOLD: assert property (ext_req && !ext_ack |=> ext_req [*3])
        else $error("request dropped");
endmodule
bind occ_ctrl occ_ctrl_asserts u_asserts (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .pslverr, .req_valid, .req_ready, .resp_done, .resp_hit, .resp_way, .cache_wr_en, .cache_wr_way,
    .line_fill, .ext_req, .ext_ack, .page_write_through, .page_cache_disable, .gp_fault);

//--- verification/occ_ext_model.sv
// External memory model
`timescale 1ns/100ps
module occ_ext_model
(
    input wire logic clk_sys,
    input wire logic ext_req,
    input wire logic noncache,
    input wire logic slow,
    output logic ext_ack,
    output logic cacheable_input_n
);
    // Cycles since the request rose
    logic [7:0] cnt_r = 8'h00;
    initial {ext_ack, cacheable_input_n} = 2'b01;
    // Answer after 4 or 12 cycles
    always @(posedge clk_sys)
    begin
        cnt_r <= ext_req ? cnt_r + 8'h01 : 8'h00;
        cacheable_input_n <= ext_req ? noncache : 1'b1;
        if (!ext_req)
            ext_ack <= 1'b0;
        else if (cnt_r == (slow ? 8'h0C : 8'h04))
            ext_ack <= 1'b1;
    end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the cache control block
`timescale 1ns/100ps
module tb_top;
    // Driven inputs
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flush_n = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, req_addr = 32'h0000_0000, inval_addr = 32'h0000_0000;
    logic req_valid = 1'b0, req_write = 1'b0, inval_valid = 1'b0, noncache = 1'b0, slow = 1'b0;
    logic [1:0] req_kind = 2'h0;
    logic pte_pwt = 1'b0, pte_pcd = 1'b0, pde_pwt = 1'b0, pde_pcd = 1'b0;
    // Observed outputs
    logic [31:0] prdata;
    logic pready, pslverr, req_ready, resp_done, resp_hit, cache_wr_en, line_fill, ext_req, ext_write;
    logic page_write_through, page_cache_disable, ext_ack, cacheable_input_n, gp_fault;
    logic [1:0] resp_way, cache_wr_way;
    logic [6:0] cache_wr_set;
    // Results
    int n_fail = 0, checked = 0;
    logic [31:0] rd = 32'h0000_0000;
    logic er = 1'b0, hit = 1'b0, fl = 1'b0, ex = 1'b0, ew = 1'b0, gf = 1'b0, pw = 1'b0, pc = 1'b0;
    logic [1:0] way = 2'h0;
    localparam logic [31:0] S5 = 32'h0000_0050, S6 = 32'h0000_0060, TG = 32'h0000_0800;
    always #2 clk_sys = ~clk_sys;
    occ_ctrl DUT (.clk_sys, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .req_valid, .req_write, .req_addr, .req_kind, .pte_pwt, .pte_pcd, .pde_pwt, .pde_pcd, .req_ready,
        .resp_done, .resp_hit, .resp_way, .cache_wr_en, .cache_wr_way, .cache_wr_set, .line_fill,
        .inval_valid, .inval_addr, .ext_req, .ext_write, .page_write_through, .page_cache_disable,
        .ext_ack, .cacheable_input_n, .flush_n, .gp_fault);
    occ_ext_model u_ext (.clk_sys, .ext_req, .noncache, .slow, .ext_ack, .cacheable_input_n);
    // Event latches
    always @(posedge clk_sys)
    begin
        if (line_fill === 1'b1) fl <= 1'b1;
        if (ext_req === 1'b1) ex <= 1'b1;
        if (ext_req === 1'b1 && ext_write === 1'b1) ew <= 1'b1;
        if (gp_fault === 1'b1) gf <= 1'b1;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) n_fail++;
        if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask
    // Core request, at = {pte_pwt, pte_pcd, pde_pwt, pde_pcd}
    task automatic core(input logic w, input logic [31:0] a, input logic [1:0] k, input logic [3:0] at);
        int n = 0;
        {req_valid, req_write, req_addr, req_kind} <= {1'b1, w, a, k};
        {pte_pwt, pte_pcd, pde_pwt, pde_pcd} <= at;
        do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 20);
        req_valid <= 1'b0;
        {fl, ex, ew} = 3'b000;
        do @(posedge clk_sys); while (resp_done !== 1'b1 && ++n < 400);
        chk(resp_done, 32'h0000_0001);
        {hit, way, pw, pc} = {resp_hit, resp_way, page_write_through, page_cache_disable};
    endtask
    // One-cycle invalidate pulse
    task automatic inval(input logic [31:0] a);
        {inval_valid, inval_addr} <= {1'b1, a};
        @(posedge clk_sys);
        inval_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Reset values, refused mode, unmapped place
    task automatic t_regs;
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        gf = 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0002);
        chk(er, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        chk(gf, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({er, rd}, {1'b1, 32'h0000_0000});
        apb(1'b1, 12'h008, 32'h0000_0001);
    endtask
    // Fills and victims
    task automatic t_fill;
        for (int t = 0; t < 4; t++)
        begin
            core(1'b0, S5 + TG * t, 2'h0, 4'h0);
            chk({hit, fl, way}, {2'b01, t[1:0]});
        end
        core(1'b0, S5, 2'h0, 4'h0);
        chk({hit, fl, way}, {2'b10, 2'h0});
        core(1'b0, S5 + TG * 4, 2'h0, 4'h0);
        chk({hit, fl, way}, {2'b01, 2'h2});
        core(1'b0, S5 + TG, 2'h0, 4'h0);
        chk({hit, way}, {1'b1, 2'h1});
        core(1'b0, S5 + TG * 5, 2'h0, 4'h0);
        chk({hit, fl, way}, {2'b01, 2'h3});
    endtask
    // Non-cacheable
    task automatic t_nocache;
        {noncache, slow} <= 2'b11;
        core(1'b0, S5 + TG * 6, 2'h0, 4'h0);
        chk({hit, fl, ex}, 3'b001);
        {noncache, slow} <= 2'b00;
        core(1'b0, S5 + TG * 6, 2'h0, 4'h4);
        chk({fl, pc}, 2'b01);
    endtask
    // Write policy
    task automatic t_write;
        core(1'b1, S6, 2'h0, 4'h0);
        chk({hit, fl, ew}, 3'b001);
        core(1'b0, S6, 2'h0, 4'h0);
        chk({hit, fl}, 2'b01);
        core(1'b1, S6, 2'h0, 4'h0);
        chk({hit, ew}, 2'b11);
    endtask
    // Disabled modes
    task automatic t_cd;
        apb(1'b1, 12'h000, 32'h0000_0001);
        core(1'b0, S6, 2'h0, 4'h0);
        chk({hit, pc}, 2'b11);
        core(1'b0, S6 + TG, 2'h0, 4'h0);
        chk({hit, fl, ex}, 3'b001);
        inval(S6);
        core(1'b0, S6, 2'h0, 4'h0);
        chk(hit, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_0003);
        core(1'b1, S5 + TG, 2'h0, 4'h0);
        chk({hit, ex}, 2'b10);
        inval(S5 + TG);
        core(1'b0, S5 + TG, 2'h0, 4'h0);
        chk({hit, fl}, 2'b10);
        apb(1'b1, 12'h000, 32'h0000_0000);
    endtask
    // Attribute sources
    task automatic t_attr;
        core(1'b0, S6 + TG * 2, 2'h0, 4'h8);
        chk({fl, pw, pc}, 3'b110);
        core(1'b0, S6 + TG * 3, 2'h1, 4'h3);
        chk({pw, pc}, 2'b11);
        apb(1'b1, 12'h004, 32'h0000_0003);
        for (int k = 2; k < 4; k++)
        begin
            core(1'b0, S6 + TG * 3, k[1:0], 4'h0);
            chk({pw, pc}, 2'b11);
        end
        apb(1'b1, 12'h004, 32'h0000_0000);
    endtask
    // Flush
    task automatic t_flush;
        apb(1'b1, 12'h00C, 32'h0000_0001);
        core(1'b0, S5, 2'h0, 4'h0);
        chk({hit, fl, way}, {2'b01, 2'h0});
    endtask
    // Verdict and end of run
    task automatic conclude;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_regs;
        t_fill;
        t_nocache;
        t_write;
        t_cd;
        t_attr;
        t_flush;
        conclude;
    end
    // Hang guard
    initial
    begin
        #100000;
        n_fail++;
        conclude;
    end
endmodule
